// ===== iomm_pkg.sv
package iomm_pkg;
  // block sizes as seen by the controller
  localparam int IN_BYTES      = 16;
  localparam int OUT_BYTES     = 8;
  localparam int IN_IDX_W      = 4;
  localparam int OUT_IDX_W     = 3;
  // module layout
  localparam int EXT_COUNT     = 3;
  localparam int IN_PER_MOD    = 3;
  localparam int OUT_PER_MOD   = 2;
  localparam int MOD_IN_BYTES  = 12;
  localparam int WHEELS        = 3;
  // input block offsets
  localparam logic [3:0] OFS_BASIC_IN  = 4'h0;
  localparam logic [3:0] OFS_EXT1_IN   = 4'h3;
  localparam logic [3:0] OFS_EXT2_IN   = 4'h6;
  localparam logic [3:0] OFS_EXT3_IN   = 4'h9;
  localparam logic [3:0] OFS_WHEEL_ONE = 4'hC;
  localparam logic [3:0] OFS_WHEEL_TWO = 4'hD;
  localparam logic [3:0] OFS_WHEEL_THR = 4'hE;
  localparam logic [3:0] OFS_DRV_ALARM = 4'hF;
  // reset and off values
  localparam logic [7:0] RST_BYTE      = 8'h00;
  localparam logic [7:0] OFF_BYTE      = 8'h00;
endpackage

// ===== iomm_drv_guard.sv
module iomm_drv_guard
  import iomm_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // requested output image and global kill
  input  wire logic [63:0] out_img,
  input  wire logic        kill_all,
  // per-byte driver fault pins, asynchronous
  input  wire logic [7:0]  drv_fault_pin,
  // driven output pins and synchronised faults
  output logic      [63:0] do_pins,
  output logic      [7:0]  fault_s
);

  logic [7:0] fault_m_r;

  ////////////////////////////////////////////////////////////////////////
  // fault pins cross in through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_m_r <= RST_BYTE;
      fault_s   <= RST_BYTE;
    end else begin
      fault_m_r <= drv_fault_pin;
      fault_s   <= fault_m_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // a faulty byte stays off only while its fault lasts; others untouched
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      do_pins <= '0;
    end else begin
      for (int k = 0; k < OUT_BYTES; k++) begin
        if (kill_all || fault_s[k]) begin
          do_pins[k*8 +: 8] <= OFF_BYTE;
        end else begin
          do_pins[k*8 +: 8] <= out_img[k*8 +: 8];
        end
      end
    end
  end

  chk_fault_hold : assert property (
    @(posedge clk) disable iff (!rst_n)
    fault_s[0] |=> do_pins[7:0] == OFF_BYTE)
    else $error("faulty byte 0 drove outputs");
  chk_healthy_bytes : assert property (
    @(posedge clk) disable iff (!rst_n)
    (!kill_all && !fault_s[1]) |=> do_pins[15:8] == $past(out_img[15:8]))
    else $error("healthy byte 1 not driven");

endmodule

// ===== iomm_unit.sv
module iomm_unit
  import iomm_pkg::*;
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // controller state from the link logic
  input  wire logic                 link_ok,
  input  wire logic                 sys_alarm,
  // input byte read port
  input  wire logic [IN_IDX_W-1:0]  in_rd_idx,
  output logic      [7:0]           in_rd_data,
  // output byte write port
  input  wire logic                 out_wr_en,
  input  wire logic [OUT_IDX_W-1:0] out_wr_idx,
  input  wire logic [7:0]           out_wr_data,
  // module pins
  input  wire logic [95:0]          input_byte_pin,
  input  wire logic [2:0]           ext_fitted_pin,
  input  wire logic [2:0]           ext_no_alarm_pin,
  input  wire logic [2:0]           wheel_a_pin,
  input  wire logic [2:0]           wheel_b_pin,
  input  wire logic [7:0]           drv_fault_pin,
  output logic      [63:0]          do_pins
);

  logic [95:0] di_m_r;
  logic [95:0] di_r;
  logic [2:0]  fit_m_r;
  logic [2:0]  fit_r;
  logic [2:0]  noal_m_r;
  logic [2:0]  noal_r;
  logic [5:0]  ab_m_r;
  logic [5:0]  ab_r;
  logic [5:0]  ab_prev_r;
  logic [2:0]  wheel_arm_r;
  logic [7:0]  wheel_cnt_r [WHEELS];
  logic [63:0] out_img_r;
  logic [7:0]  fault_s;
  logic [7:0]  alarm_byte;
  logic [7:0]  alarm_mask;
  logic [7:0]  in_map [IN_BYTES];
  logic        kill_all;

  // quadrature step: 01 up, 11 down, 00 none
  function automatic logic [1:0] quad_step(input logic [1:0] was,
                                           input logic [1:0] now);
    logic [3:0] t;
    t = {was, now};
    case (t)
      4'h1, 4'h7, 4'hE, 4'h8: quad_step = 2'h1;
      4'h2, 4'hB, 4'hD, 4'h4: quad_step = 2'h3;
      default:                quad_step = 2'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pins cross in through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      di_m_r   <= '0;
      di_r     <= '0;
      fit_m_r  <= '0;
      fit_r    <= '0;
      noal_m_r <= '0;
      noal_r   <= '0;
      ab_m_r   <= '0;
      ab_r     <= '0;
    end else begin
      di_m_r   <= input_byte_pin;
      di_r     <= di_m_r;
      fit_m_r  <= ext_fitted_pin;
      fit_r    <= fit_m_r;
      noal_m_r <= ext_no_alarm_pin;
      noal_r   <= noal_m_r;
      ab_m_r   <= {wheel_b_pin, wheel_a_pin};
      ab_r     <= ab_m_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // handwheel counters, free running and wrapping
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ab_prev_r   <= '0;
      wheel_arm_r <= '0;
      for (int w = 0; w < WHEELS; w++) begin
        wheel_cnt_r[w] <= RST_BYTE;
      end
    end else begin
      ab_prev_r   <= ab_r;
      // sync chain wakes at zero; no false step until it holds real levels
      wheel_arm_r <= {wheel_arm_r[1:0], 1'h1};
      for (int w = 0; w < WHEELS; w++) begin
        if (wheel_arm_r[2]) begin
          case (quad_step({ab_prev_r[w+3], ab_prev_r[w]},
                          {ab_r[w+3], ab_r[w]}))
            2'h1:    wheel_cnt_r[w] <= wheel_cnt_r[w] + 8'h01;
            2'h3:    wheel_cnt_r[w] <= wheel_cnt_r[w] - 8'h01;
            default: wheel_cnt_r[w] <= wheel_cnt_r[w];
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output image from the controller; kept through a kill so the
  // outputs come back as last written once the link recovers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_img_r <= '0;
    end else if (out_wr_en) begin
      out_img_r[out_wr_idx*8 +: 8] <= out_wr_data;
    end
  end

  assign kill_all = sys_alarm || !link_ok;

  iomm_drv_guard u_guard (
    .clk           (clk),
    .rst_n         (rst_n),
    .out_img       (out_img_r),
    .kill_all      (kill_all),
    .drv_fault_pin (drv_fault_pin),
    .do_pins       (do_pins),
    .fault_s       (fault_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // alarm byte: bit k is output byte k, masked where unsupported
  always_comb begin
    alarm_mask = 8'hFF;
    for (int e = 0; e < EXT_COUNT; e++) begin
      if (noal_r[e]) begin
        alarm_mask[2*e+2 +: 2] = 2'h0;
      end
    end
    alarm_byte = fault_s & alarm_mask;
  end

  ////////////////////////////////////////////////////////////////////////
  // input block map; absent extensions read zero but never shift others
  always_comb begin
    for (int b = 0; b < MOD_IN_BYTES; b++) begin
      in_map[b] = di_r[b*8 +: 8];
      if (b >= IN_PER_MOD && !fit_r[b/IN_PER_MOD-1]) begin
        in_map[b] = RST_BYTE;
      end
    end
    in_map[OFS_WHEEL_ONE] = wheel_cnt_r[0];
    in_map[OFS_WHEEL_TWO] = wheel_cnt_r[1];
    in_map[OFS_WHEEL_THR] = wheel_cnt_r[2];
    in_map[OFS_DRV_ALARM] = alarm_byte;
  end

  // registered read, one cycle after the index
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_rd_data <= RST_BYTE;
    end else begin
      in_rd_data <= in_map[in_rd_idx];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  chk_kill_outputs : assert property (
    @(posedge clk) disable iff (!rst_n)
    (sys_alarm || !link_ok) |=> do_pins == 64'h0)
    else $error("outputs live during alarm or link loss");
  chk_alarm_read : assert property (
    @(posedge clk) disable iff (!rst_n)
    in_rd_idx == OFS_DRV_ALARM |=> in_rd_data == $past(alarm_byte))
    else $error("offset 15 is not the alarm byte");
  chk_alarm_bits : assert property (
    @(posedge clk) disable iff (!rst_n)
    (fault_s[3] && !noal_r[0]) |-> alarm_byte[3])
    else $error("fault on byte 3 not flagged");
  chk_alarm_mask : assert property (
    @(posedge clk) disable iff (!rst_n)
    noal_r[2] |-> alarm_byte[7:6] == 2'h0)
    else $error("unsupported position reported alarm");
  chk_wheel_read : assert property (
    @(posedge clk) disable iff (!rst_n)
    in_rd_idx == OFS_WHEEL_TWO |=> in_rd_data == $past(wheel_cnt_r[1]))
    else $error("offset 13 is not wheel two");
  chk_absent_ext : assert property (
    @(posedge clk) disable iff (!rst_n)
    (in_rd_idx == OFS_EXT2_IN && !fit_r[1]) |=> in_rd_data == RST_BYTE)
    else $error("absent extension read nonzero");
  chk_ext_map : assert property (
    @(posedge clk) disable iff (!rst_n)
    (in_rd_idx == OFS_EXT3_IN && fit_r[2]) |=>
      in_rd_data == $past(di_r[79:72]))
    else $error("third extension byte misplaced");
  chk_out_write : assert property (
    @(posedge clk) disable iff (!rst_n)
    (out_wr_en && out_wr_idx == 3'h7) |=>
      out_img_r[63:56] == $past(out_wr_data))
    else $error("output byte 7 not stored");
  chk_fault_local : assert property (
    @(posedge clk) disable iff (!rst_n)
    (fault_s[0] && !kill_all && !fault_s[2]) |=>
      do_pins[23:16] == $past(out_img_r[23:16]))
    else $error("fault spilled onto another byte");

endmodule

// ===== iomm_ctl_model.sv
module iomm_ctl_model
  import iomm_pkg::*;
(
  // clock
  input  wire logic                 clk,
  // read port
  output logic      [IN_IDX_W-1:0]  in_rd_idx,
  input  wire logic [7:0]           in_rd_data,
  // write port
  output logic                      out_wr_en,
  output logic      [OUT_IDX_W-1:0] out_wr_idx,
  output logic      [7:0]           out_wr_data,
  // controller state
  output logic                      link_ok,
  output logic                      sys_alarm
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    in_rd_idx   = '0;
    out_wr_en   = 1'h0;
    out_wr_idx  = '0;
    out_wr_data = 8'h00;
    link_ok     = 1'h1;
    sys_alarm   = 1'h0;
  end
  // wheel bytes are handed up, never used as logic
  // block placement is settled outside this model
  // data taken two edges after launch, so the launching edge never races
  task rd(input logic [IN_IDX_W-1:0] i, output logic [7:0] d);
    @(posedge clk);
    in_rd_idx <= i;
    repeat (2) @(posedge clk);
    d = in_rd_data;
  endtask
  // data inverted after the strobe so stale bytes never look valid
  task wr(input logic [OUT_IDX_W-1:0] i, input logic [7:0] d);
    @(posedge clk);
    out_wr_en   <= 1'h1;
    out_wr_idx  <= i;
    out_wr_data <= d;
    @(posedge clk);
    out_wr_en   <= 1'h0;
    out_wr_data <= ~d;
  endtask
  task state(input logic ok, input logic al);
    @(posedge clk);
    link_ok   <= ok;
    sys_alarm <= al;
  endtask
endmodule

// ===== tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import iomm_pkg::*;
  logic        clk     = 1'h0;
  logic        rst_n   = 1'h0;
  logic [95:0] in_pins = '0;
  logic [2:0]  fit     = 3'h7;
  logic [2:0]  no_al   = 3'h0;
  logic [7:0]  flt     = 8'h00;
  logic [15:0] lfsr_r  = 16'h4BD1;
  logic [3:0]  rd_idx;
  logic [7:0]  rd_data;
  logic [2:0]  wr_idx;
  logic [7:0]  wr_data;
  logic        wr_en;
  logic        ok;
  logic        alarm;
  logic [63:0] do_pins;
  logic [7:0]  v;
  logic [95:0] pins_v;
  logic [5:0]  ab_v;
  logic [2:0]  wa      = 3'h0;
  logic [2:0]  wb      = 3'h0;
  int          error_cnt = 0;
  int          n_checks  = 0;
  int          cyc       = 0;
  int          img[8];
  int          ph[3];
  int          wcnt[3];
  always #50 clk = ~clk;
  iomm_ctl_model ctl (.clk(clk), .in_rd_idx(rd_idx), .in_rd_data(rd_data),
    .out_wr_en(wr_en), .out_wr_idx(wr_idx), .out_wr_data(wr_data),
    .link_ok(ok), .sys_alarm(alarm));
  iomm_unit DUT (.clk(clk), .rst_n(rst_n), .link_ok(ok), .sys_alarm(alarm),
    .in_rd_idx(rd_idx), .in_rd_data(rd_data), .out_wr_en(wr_en),
    .out_wr_idx(wr_idx), .out_wr_data(wr_data), .input_byte_pin(in_pins),
    .ext_fitted_pin(fit), .ext_no_alarm_pin(no_al), .wheel_a_pin(wa),
    .wheel_b_pin(wb), .drv_fault_pin(flt), .do_pins(do_pins));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    lfsr_r = {lfsr_r[14:0],
              lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    return lfsr_r[7:0];
  endfunction
  task chk(input string nm, input logic [63:0] e, input logic [63:0] s);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task rd_chk(input int i, input logic [7:0] e);
    logic [7:0] d;
    ctl.rd(4'(i), d);
    chk("input byte", {56'h0, e}, {56'h0, d});
  endtask
  // absent extension and idle wheels read zero
  function logic [7:0] exp_in(input int b);
    if (b >= 12 || (b >= 3 && !fit[b / 3 - 1])) return 8'h00;
    return in_pins[b * 8 +: 8];
  endfunction
  function logic [63:0] exp_do(input logic kill, input logic [7:0] f);
    for (int k = 0; k < 8; k++)
      exp_do[k * 8 +: 8] = (kill || f[k]) ? 8'h00 : 8'(img[k]);
  endfunction
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ceiling well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    chk("do reset", 64'h0, do_pins);
    for (int b = 0; b < 12; b++) begin
      pins_v[b * 8 +: 8] = rnd();
    end
    in_pins <= pins_v;
    for (int p = 0; p < 2; p++) begin
      fit <= p ? 3'h5 : 3'h7;
      repeat (4) @(posedge clk);
      for (int b = 0; b < 16; b++)
        rd_chk(b, exp_in(b));
    end
    $display("test input map done");
    for (int k = 0; k < 8; k++) begin
      v = rnd();
      img[k] = v;
      ctl.wr(3'(k), v);
    end
    repeat (3) @(posedge clk);
    chk("do image", exp_do(1'h0, 8'h00), do_pins);
    $display("test output map done");
    for (int t = 0; t < 3; t++) begin
      v = rnd();
      flt <= v;
      repeat (5) @(posedge clk);
      chk("do fault", exp_do(1'h0, v), do_pins);
      rd_chk(15, v);
      rd_chk(0, in_pins[7:0]);
    end
    // second and third extensions unsupported: bits 4 to 7 stay clear
    no_al <= 3'h6;
    flt   <= 8'hFC;
    repeat (5) @(posedge clk);
    chk("do masked", exp_do(1'h0, 8'hFC), do_pins);
    rd_chk(15, 8'h0C);
    flt   <= 8'h00;
    no_al <= 3'h0;
    repeat (5) @(posedge clk);
    chk("do recover", exp_do(1'h0, 8'h00), do_pins);
    $display("test driver fault done");
    // first pass loses the link, second raises the system alarm
    for (int t = 0; t < 2; t++) begin
      ctl.state(t[0], t[0]);
      repeat (3) @(posedge clk);
      chk("do kill", exp_do(1'h1, 8'h00), do_pins);
      ctl.state(1'h1, 1'h0);
      repeat (3) @(posedge clk);
      chk("do resume", exp_do(1'h0, 8'h00), do_pins);
    end
    $display("test kill done");
    // quadrature phases 00 01 11 10 count up, the reverse counts down
    for (int s = 0; s < 40; s++) begin
      v = rnd();
      for (int w = 0; w < 3; w++) begin
        ph[w]     = (ph[w] + (v[w] ? 1 : 3)) % 4;
        wcnt[w]   = (wcnt[w] + (v[w] ? 1 : 255)) % 256;
        ab_v[w]   = ph[w][1] ^ ph[w][0];
        ab_v[w+3] = ph[w][1];
      end
      {wb, wa} <= ab_v;
      repeat (2) @(posedge clk);
    end
    repeat (4) @(posedge clk);
    for (int w = 0; w < 3; w++)
      rd_chk(12 + w, 8'(wcnt[w]));
    $display("test handwheel done");
    complete_run;
  end
endmodule
